// File: hw/sbc_pkg.sv
// ****************************************************************
// Shared constants and types for the SRAM base/config block
// ****************************************************************
package sbc_pkg;

	// Register field positions
	localparam int SBC_VALID_BIT = 0;
	localparam int SBC_MASK_LSB = 1;
	localparam int SBC_MASK_MSB = 5;
	localparam int SBC_WP_BIT = 8;
	localparam int SBC_DMA_GATE_BIT = 9;
	localparam int SBC_LOWER_PRI_BIT = 10;
	localparam int SBC_UPPER_PRI_BIT = 11;
	localparam int SBC_BASE_LSB = 16;
	localparam int SBC_BASE_MSB = 31;

	// Geometry of the array
	localparam int SBC_ADDR_W = 16;
	localparam int SBC_BANK_BIT = 15;
	localparam int SBC_WORD_LSB = 2;
	localparam int SBC_DATA_W = 32;
	localparam int SBC_BANKS = 2;

	// Access sizes
	localparam logic [1:0] SBC_SIZE_BYTE = 2'h0;
	localparam logic [1:0] SBC_SIZE_WORD = 2'h1;
	localparam logic [1:0] SBC_SIZE_LONG = 2'h2;

	// Priority bit value that hands a bank to the core
	localparam logic SBC_PRI_CPU = 1'h1;

	// Address space of a core reference; order matches mask bits 1..5
	typedef enum logic [2:0] {
		SBC_SPC_USER_DATA,
		SBC_SPC_USER_CODE,
		SBC_SPC_SUPER_DATA,
		SBC_SPC_SUPER_CODE,
		SBC_SPC_CPU_IACK
	} sbc_space_t;

	// Defined fields of the base/config register
	typedef struct packed {
		logic [15:0] base;
		logic upperBankPriority;
		logic lowerBankPriority;
		logic dmaAccessGate;
		logic writeProtect;
		logic [4:0] spaceMaskBits;
		logic valid;
	} sbc_cfg_t;

	// One memory request from a master
	typedef struct packed {
		logic req;
		logic write;
		logic [1:0] size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} sbc_req_t;

endpackage : sbc_pkg

// File: hw/sbc_sram_bank.sv
`timescale 1ns/1ps
// ****************************************************************
// One physical array bank, single port, byte lane writes
// ****************************************************************
module sbc_sram_bank
	import sbc_pkg::*;
#(
	parameter int DEPTH = 8192,
	parameter int IDX_W = 13
)
(
	input wire logic clk,
	input wire logic en,
	input wire logic we,
	input wire logic [3:0] be,
	input wire logic [IDX_W-1:0] idx,
	input wire logic [SBC_DATA_W-1:0] wdata,
	output logic [SBC_DATA_W-1:0] rdata
);

	// Array storage, no reset: contents undefined after reset
	logic [SBC_DATA_W-1:0] mem [DEPTH];
	logic [SBC_DATA_W-1:0] next_rdata;

	// Read data for the word addressed this cycle
	always_comb
	begin
		next_rdata = rdata;
		if (en)
		begin
			next_rdata = mem[idx];
		end
	end

	// Register the read word; write enabled byte lanes
	always_ff @(posedge clk)
	begin
		rdata <= next_rdata;
		if (en && we)
		begin
			for (int i = 0; i < 4; i++)
			begin
				if (be[i])
				begin
					mem[idx][i*8 +: 8] <= wdata[i*8 +: 8];
				end
			end
		end
	end

endmodule : sbc_sram_bank

// File: hw/sbc_sram_ctrl.sv
`timescale 1ns/1ps
// Contract
// - Core writes config register, cannot read it
// - Debug module reads and writes config register
// - Undefined bits ignore writes, read zero
// - Reset clears only valid; rest kept
// - Valid bit 0 enables the SRAM
// - Bits 11-10 set upper/lower bank priority
// - Write protect bit 8: writes raise error
// - Set space mask bypasses the SRAM
// - Array contents undefined after reset
// - Base is any 64K boundary; region served
// - Any access size completes in one cycle
// - Two arrays allow core and DMA together
module sbc_sram_ctrl
	import sbc_pkg::*;
#(
	parameter int BANK_DEPTH = 8192
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic cfgWrite,
	input wire logic [31:0] cfgWdata,
	input wire logic dbgWrite,
	input wire logic dbgRead,
	input wire logic [31:0] dbgWdata,
	output logic [31:0] dbgRdata,
	input wire sbc_req_t cpuIn,
	input wire sbc_space_t cpuSpace,
	output logic cpuHit,
	output logic cpuReady,
	output logic cpuStall,
	output logic cpuAccessError,
	output logic [31:0] cpuRdata,
	input wire sbc_req_t dmaIn,
	output logic dmaReady,
	output logic dmaStall,
	output logic dmaAccessError,
	output logic [31:0] dmaRdata,
	output sbc_cfg_t cfgView
);

	localparam int IDX_W = SBC_BANK_BIT - SBC_WORD_LSB;

	// ****************************************************************
	// Helper functions
	// ****************************************************************

	// Lane enables, big-endian: byte 0 sits in bits 31:24
	function automatic logic [3:0] laneEnables(input logic [1:0] size,
		input logic [1:0] lo);
		logic [3:0] be;
		be = 4'hF;
		case (size)
			SBC_SIZE_BYTE: be = 4'h8 >> lo;
			SBC_SIZE_WORD: be = lo[1] ? 4'h3 : 4'hC;
			default: be = 4'hF;
		endcase
		return be;
	endfunction : laneEnables

	// Take the defined fields out of a written word
	function automatic sbc_cfg_t unpackCfg(input logic [31:0] w);
		sbc_cfg_t c;
		c.base = w[SBC_BASE_MSB:SBC_BASE_LSB];
		c.upperBankPriority = w[SBC_UPPER_PRI_BIT];
		c.lowerBankPriority = w[SBC_LOWER_PRI_BIT];
		c.dmaAccessGate = w[SBC_DMA_GATE_BIT];
		c.writeProtect = w[SBC_WP_BIT];
		c.spaceMaskBits = w[SBC_MASK_MSB:SBC_MASK_LSB];
		c.valid = w[SBC_VALID_BIT];
		return c;
	endfunction : unpackCfg

	// Rebuild the register word; undefined bits read zero
	function automatic logic [31:0] packCfg(input sbc_cfg_t c);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[SBC_BASE_MSB:SBC_BASE_LSB] = c.base;
		w[SBC_UPPER_PRI_BIT] = c.upperBankPriority;
		w[SBC_LOWER_PRI_BIT] = c.lowerBankPriority;
		w[SBC_DMA_GATE_BIT] = c.dmaAccessGate;
		w[SBC_WP_BIT] = c.writeProtect;
		w[SBC_MASK_MSB:SBC_MASK_LSB] = c.spaceMaskBits;
		w[SBC_VALID_BIT] = c.valid;
		return w;
	endfunction : packCfg

	// ****************************************************************
	// Base/config register and debug read path
	// ****************************************************************

	sbc_cfg_t cfg; // Live register
	sbc_cfg_t next_cfg;
	logic [31:0] next_dbgRdata;

	// Debug write beats core write in the same cycle
	always_comb
	begin
		next_cfg = cfg;
		next_dbgRdata = dbgRdata;
		if (!resetn)
		begin
			next_cfg.valid = 1'b0;
			next_dbgRdata = 32'h0000_0000;
		end
		else
		begin
			if (dbgWrite)
			begin
				next_cfg = unpackCfg(dbgWdata);
			end
			else if (cfgWrite)
			begin
				next_cfg = unpackCfg(cfgWdata);
			end
			if (dbgRead)
			begin
				next_dbgRdata = packCfg(cfg);
			end
		end
	end

	// Fields other than valid carry no reset value
	always_ff @(posedge clk)
	begin
		cfg <= next_cfg;
		dbgRdata <= next_dbgRdata;
	end

	assign cfgView = cfg;

	// ****************************************************************
	// Decode and bank arbitration
	// ****************************************************************

	logic cpuInRegion; // Address falls inside the mapped 64K window
	logic cpuMasked; // Space mask bit for this reference is set
	logic cpuBank;
	logic dmaBank;
	logic dmaOn; // DMA request allowed by valid and gate
	logic clash; // Both masters want the same bank
	logic cpuPri; // Core holds priority in the contested bank
	logic cpuGo;
	logic dmaGo;

	always_comb
	begin
		cpuInRegion = cfg.valid &&
			(cpuIn.addr[SBC_BASE_MSB:SBC_BASE_LSB] == cfg.base);
		cpuMasked = cfg.spaceMaskBits[cpuSpace];
		cpuHit = cpuIn.req && cpuInRegion && !cpuMasked;
		cpuBank = cpuIn.addr[SBC_BANK_BIT];
		dmaBank = dmaIn.addr[SBC_BANK_BIT];
		dmaOn = dmaIn.req && cfg.valid && cfg.dmaAccessGate;
		clash = cpuHit && dmaOn && (cpuBank == dmaBank);
		// Upper bank follows bit 11, lower bank bit 10
		cpuPri = (cpuBank ? cfg.upperBankPriority
			: cfg.lowerBankPriority) == SBC_PRI_CPU;
		cpuGo = cpuHit && (!clash || cpuPri);
		dmaGo = dmaOn && (!clash || !cpuPri);
		cpuReady = cpuGo;
		cpuStall = cpuHit && !cpuGo;
		dmaReady = dmaGo;
		dmaStall = dmaOn && !dmaGo;
		cpuAccessError = cpuGo && cpuIn.write && cfg.writeProtect;
		dmaAccessError = dmaGo && dmaIn.write && cfg.writeProtect;
	end

	// ****************************************************************
	// Bank port steering
	// ****************************************************************

	logic bankEn [SBC_BANKS];
	logic bankWe [SBC_BANKS];
	logic [3:0] bankBe [SBC_BANKS];
	logic [IDX_W-1:0] bankIdx [SBC_BANKS];
	logic [31:0] bankWdata [SBC_BANKS];
	logic [31:0] bankRdata [SBC_BANKS];

	// Each bank serves at most one master per cycle
	always_comb
	begin
		for (int b = 0; b < SBC_BANKS; b++)
		begin
			bankEn[b] = 1'b0;
			bankWe[b] = 1'b0;
			bankBe[b] = laneEnables(cpuIn.size, cpuIn.addr[1:0]);
			bankIdx[b] = cpuIn.addr[SBC_BANK_BIT-1:SBC_WORD_LSB];
			bankWdata[b] = cpuIn.wdata;
			if (cpuGo && (cpuBank == b[0]))
			begin
				bankEn[b] = 1'b1;
				bankWe[b] = cpuIn.write && !cfg.writeProtect;
			end
			else if (dmaGo && (dmaBank == b[0]))
			begin
				bankEn[b] = 1'b1;
				bankWe[b] = dmaIn.write && !cfg.writeProtect;
				bankBe[b] = laneEnables(dmaIn.size, dmaIn.addr[1:0]);
				bankIdx[b] = dmaIn.addr[SBC_BANK_BIT-1:SBC_WORD_LSB];
				bankWdata[b] = dmaIn.wdata;
			end
		end
	end

	// Two physical arrays, contents left unset by reset
	for (genvar g = 0; g < SBC_BANKS; g++)
	begin : gBank
		sbc_sram_bank #(
			.DEPTH(BANK_DEPTH),
			.IDX_W(IDX_W)
		) uBank (
			.clk(clk),
			.en(bankEn[g]),
			.we(bankWe[g]),
			.be(bankBe[g]),
			.idx(bankIdx[g]),
			.wdata(bankWdata[g]),
			.rdata(bankRdata[g])
		);
	end

	// ****************************************************************
	// Read return steering
	// ****************************************************************

	logic cpuBankQ; // Bank used by last core access
	logic dmaBankQ; // Bank used by last DMA access
	logic next_cpuBankQ;
	logic next_dmaBankQ;

	// Remember which bank each master used
	always_comb
	begin
		next_cpuBankQ = cpuGo ? cpuBank : cpuBankQ;
		next_dmaBankQ = dmaGo ? dmaBank : dmaBankQ;
		if (!resetn)
		begin
			next_cpuBankQ = 1'b0;
			next_dmaBankQ = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		cpuBankQ <= next_cpuBankQ;
		dmaBankQ <= next_dmaBankQ;
	end

	// Registered bank words, whole longword returned
	assign cpuRdata = bankRdata[cpuBankQ];
	assign dmaRdata = bankRdata[dmaBankQ];

endmodule : sbc_sram_ctrl

// File: verif/sbc_dma_model.sv
`timescale 1ns/1ps
// ********
// DMA master: one longword read, held until answered or cancelled
// ********
module sbc_dma_model
	import sbc_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic start,
	input wire logic cancel,
	input wire logic [15:0] offset,
	input wire logic dmaReady,
	output sbc_req_t dmaIn
);
	// Request for the coming cycle
	sbc_req_t next_dmaIn;
	// Raise on start; qualifiers frozen until ready or cancel
	always_comb
	begin
		next_dmaIn = dmaIn;
		if (!resetn)
			next_dmaIn = '0;
		else if (!dmaIn.req)
		begin
			next_dmaIn.req = start;
			// Unused write data toggles only while idle, held when waiting
			next_dmaIn.wdata = ~dmaIn.wdata;
			next_dmaIn.size = SBC_SIZE_LONG;
			next_dmaIn.addr = {16'h0, offset};
		end
		else if (dmaReady || cancel)
			next_dmaIn.req = 1'b0;
	end
	// Register only
	always_ff @(posedge clk) dmaIn <= next_dmaIn;
endmodule : sbc_dma_model

// File: verif/sbc_sram_ctrl_properties.sv
`timescale 1ns/1ps
// ********
// Port checker for the SRAM base/config controller
// ********
module sbc_sram_ctrl_properties
	import sbc_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic cfgWrite,
	input wire logic [31:0] cfgWdata,
	input wire logic dbgWrite,
	input wire logic dbgRead,
	input wire logic [31:0] dbgWdata,
	input wire logic [31:0] dbgRdata,
	input wire sbc_req_t cpuIn,
	input wire sbc_space_t cpuSpace,
	input wire logic cpuHit,
	input wire logic cpuReady,
	input wire logic cpuStall,
	input wire logic cpuAccessError,
	input wire sbc_req_t dmaIn,
	input wire logic dmaReady,
	input wire logic dmaStall,
	input wire logic dmaAccessError,
	input wire sbc_cfg_t cfgView
);
	// Set once a write lands, so kept bits are known values
	logic seenWrite = 1'b0;
	logic next_seenWrite;
	// DMA may use the array
	logic dmaLive;
	// Defined fields of a written word
	function automatic sbc_cfg_t fields(input logic [31:0] w);
		return {w[31:16], w[11:8], w[5:1], w[0]};
	endfunction : fields
	// Word seen by a debug read
	function automatic logic [31:0] word(input sbc_cfg_t c);
		return {c.base, 4'h0, c[9:6], 2'h0, c[5:0]};
	endfunction : word
	// Helper state
	always_comb next_seenWrite = seenWrite | (resetn & (cfgWrite | dbgWrite));
	always_ff @(posedge clk) seenWrite <= next_seenWrite;
	assign dmaLive = cfgView.valid & cfgView.dmaAccessGate;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	a_reset_valid: assert property (disable iff (1'b0)
		!resetn |=> !cfgView.valid) else $error("valid kept over reset");
	a_reset_keep: assert property (disable iff (1'b0)
		!resetn && seenWrite |=> cfgView[25:1] == $past(cfgView[25:1]))
		else $error("fields lost over reset");
	a_dbg_load: assert property (dbgWrite
		|=> cfgView == fields($past(dbgWdata))) else $error("debug write");
	a_core_load: assert property (cfgWrite && !dbgWrite
		|=> cfgView == fields($past(cfgWdata))) else $error("core write");
	a_dbg_read: assert property (dbgRead && !dbgWrite && !cfgWrite
		|=> dbgRdata == word($past(cfgView))) else $error("debug read");
	a_hit_decode: assert property (
		cpuHit == (cpuIn.req && cfgView.valid
		&& cpuIn.addr[31:16] == cfgView.base
		&& !cfgView.spaceMaskBits[cpuSpace])) else $error("hit decode");
	a_one_cycle: assert property (cpuReady == (cpuHit && !cpuStall))
		else $error("core access not single cycle");
	a_wp_error: assert property (cpuAccessError == (cpuReady
		&& cpuIn.write && cfgView.writeProtect)) else $error("protect error");
	a_bank_arbit: assert property (
		cpuStall == (cpuHit && dmaIn.req
		&& dmaLive && dmaIn.addr[15] == cpuIn.addr[15]
		&& !(cpuIn.addr[15] ? cfgView.upperBankPriority
		: cfgView.lowerBankPriority))) else $error("bank arbitration");
	a_dma_gate: assert property (dmaReady |-> dmaLive)
		else $error("DMA served while gated");
	a_dma_stall: assert property (dmaStall == (dmaIn.req && dmaLive
		&& !dmaReady)) else $error("DMA stall");
	a_dma_error: assert property (dmaAccessError == (dmaReady
		&& dmaIn.write && cfgView.writeProtect)) else $error("DMA protect");
	a_bank_excl: assert property (!(cpuReady && dmaReady
		&& cpuIn.addr[15] == dmaIn.addr[15])) else $error("bank shared");
	c_dbg_read: cover property (dbgRead);
	c_stall: cover property (cpuStall);
	c_error: cover property (cpuAccessError);
endmodule : sbc_sram_ctrl_properties
bind sbc_sram_ctrl sbc_sram_ctrl_properties sbc_sram_ctrl_properties_inst (
	.clk(clk), .resetn(resetn), .cfgWrite(cfgWrite), .cfgWdata(cfgWdata),
	.dbgWrite(dbgWrite), .dbgRead(dbgRead), .dbgWdata(dbgWdata),
	.dbgRdata(dbgRdata), .cpuIn(cpuIn), .cpuSpace(cpuSpace), .cpuHit(cpuHit),
	.cpuReady(cpuReady), .cpuStall(cpuStall), .dmaIn(dmaIn),
	.cpuAccessError(cpuAccessError), .dmaReady(dmaReady),
	.dmaStall(dmaStall), .dmaAccessError(dmaAccessError), .cfgView(cfgView));

// File: verif/sbc_sram_ctrl_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
	err_count++; $display("unexpected %s exp %h got %h", n, e, g); end end
// ********
// Bench: core, debug and DMA around the controller
// ********
module sbc_sram_ctrl_tb_top
	import sbc_pkg::*;
;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic cfgWrite = 1'b0;
	logic dbgWrite = 1'b0;
	logic dbgRead = 1'b0;
	logic [31:0] cfgWdata = '0;
	logic [31:0] dbgWdata = '0;
	sbc_req_t cpuIn = '0;
	sbc_space_t cpuSpace = SBC_SPC_USER_DATA;
	logic dmaStart = 1'b0;
	logic dmaCancel = 1'b0;
	logic [15:0] dmaOffset = '0;
	logic [31:0] dbgRdata, cpuRdata, dmaRdata, rd;
	logic cpuHit, cpuReady, cpuStall, cpuAccessError, h, s, e;
	logic dmaReady, dmaStall, dmaAccessError;
	sbc_req_t dmaIn;
	sbc_cfg_t cfgView;
	int err_count = 0;
	int checks_done = 0;
	localparam logic [31:0] A = 32'h2000_0010;
	always #50 clk = ~clk;
	sbc_sram_ctrl sbc_sram_ctrl_inst (.clk(clk), .resetn(resetn),
		.cfgWrite(cfgWrite), .cfgWdata(cfgWdata), .dbgWrite(dbgWrite),
		.dbgRead(dbgRead), .dbgWdata(dbgWdata), .dbgRdata(dbgRdata),
		.cpuIn(cpuIn), .cpuSpace(cpuSpace), .cpuHit(cpuHit),
		.cpuReady(cpuReady), .cpuStall(cpuStall), .cpuRdata(cpuRdata),
		.cpuAccessError(cpuAccessError), .dmaIn(dmaIn), .dmaReady(dmaReady),
		.dmaStall(dmaStall), .dmaAccessError(dmaAccessError),
		.dmaRdata(dmaRdata), .cfgView(cfgView));
	sbc_dma_model sbc_dma_model_inst (.clk(clk), .resetn(resetn),
		.start(dmaStart), .cancel(dmaCancel), .offset(dmaOffset),
		.dmaReady(dmaReady), .dmaIn(dmaIn));
	// Verdict and end of run
	task automatic report_and_stop;
		if (err_count == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop
	// Register write, core or debug path
	task automatic reg_wr(input logic dbg, input logic [31:0] d);
		@(posedge clk);
		cfgWrite <= !dbg;
		dbgWrite <= dbg;
		cfgWdata <= d;
		dbgWdata <= d;
		@(posedge clk);
		cfgWrite <= 1'b0;
		dbgWrite <= 1'b0;
	endtask : reg_wr
	// Debug read and compare
	task automatic reg_rd(input logic [31:0] x);
		@(posedge clk);
		dbgRead <= 1'b1;
		@(posedge clk);
		dbgRead <= 1'b0;
		@(negedge clk);
		`CHK("dbgRdata", x, dbgRdata)
	endtask : reg_rd
	// Core longword access, held while stalled
	task automatic cpu(input logic w, input logic [31:0] a, input int sp);
		@(posedge clk);
		cpuIn <= '{1'b1, w, SBC_SIZE_LONG, a, 32'hDEAD_BEEF ^ a ^ sp};
		cpuSpace <= sbc_space_t'(sp);
		dmaStart <= 1'b0;
		@(negedge clk);
		h = cpuHit;
		s = cpuStall;
		e = cpuAccessError;
		for (int k = 0; k < 4 && cpuStall === 1'b1; k++) @(negedge clk);
		@(posedge clk);
		cpuIn.req <= 1'b0;
		@(negedge clk);
		rd = cpuRdata;
	endtask : cpu
	// DMA read launched to meet a core read
	task automatic clash(input int code, input int db, input int cb);
		reg_wr(1'b0, 32'h2000_0201 | (code << 10));
		@(posedge clk);
		dmaOffset <= db ? 16'h8000 : 16'h0010;
		dmaStart <= 1'b1;
		cpu(1'b0, 32'h2000_0000 | (cb << 15), 0);
	endtask : clash
	// Main sequence
	initial
	begin
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		reg_wr(1'b1, 32'hFFFF_FFFF);
		reg_rd(32'hFFFF_0F3F);
		reg_wr(1'b0, 32'h2000_0201);
		reg_rd(32'h2000_0201);
		cpu(1'b1, A, 0);
		`CHK("cpuHit", 1'b1, h)
		cpu(1'b0, A, 0);
		`CHK("cpuRdata", 32'hDEAD_BEEF ^ A, rd)
		cpu(1'b0, A | 32'h1_0000, 0);
		`CHK("cpuHit", 1'b0, h)
		for (int i = 0; i < 5; i++)
		begin
			reg_wr(1'b0, 32'h2000_0201 | (32'h2 << i));
			cpu(1'b0, A, i);
			`CHK("cpuHit", 1'b0, h)
			cpu(1'b0, A, (i + 1) % 5);
			`CHK("cpuHit", 1'b1, h)
		end
		reg_wr(1'b0, 32'h2000_0301);
		cpu(1'b1, A, 1);
		`CHK("cpuAccessError", 1'b1, e)
		cpu(1'b0, A, 1);
		`CHK("cpuRdata", 32'hDEAD_BEEF ^ A, rd)
		for (int i = 0; i < 8; i++)
		begin
			clash(i / 2, i % 2, i % 2);
			`CHK("cpuStall", ((i / 2) >> (i % 2)) % 2 == 0, s)
		end
		clash(0, 0, 1);
		`CHK("cpuStall", 1'b0, s)
		`CHK("dmaRdata", 32'hDEAD_BEEF ^ A, dmaRdata)
		reg_wr(1'b0, 32'h2000_0001);
		@(posedge clk);
		dmaStart <= 1'b1;
		@(posedge clk);
		dmaStart <= 1'b0;
		@(negedge clk);
		`CHK("dmaReady", 1'b0, dmaReady)
		@(posedge clk);
		dmaCancel <= 1'b1;
		resetn <= 1'b0;
		repeat (2) @(posedge clk);
		dmaCancel <= 1'b0;
		resetn <= 1'b1;
		reg_rd(32'h2000_0000);
		cpu(1'b0, A, 0);
		`CHK("cpuHit", 1'b0, h)
		report_and_stop();
	end
	// Watchdog
	initial
	begin
		repeat (3000) @(posedge clk);
		err_count++;
		report_and_stop();
	end
endmodule : sbc_sram_ctrl_tb_top
